// *** hw/synth_ctrl_defines.vh ***
// constants of the synthesizer control register bank
// assumes inclusion by every design file of the bank, with no package available
`ifndef SYNTH_CTRL_DEFINES_VH
`define SYNTH_CTRL_DEFINES_VH
// serial frame: read flag, 7-bit address, 8-bit data, msb first
`define FRAME_BITS 5'h10
`define HEAD_LAST 5'h07
`define FRAME_LAST 5'h0f
// register offsets
`define ADDR_FRAC_BYTE_LOW 7'h00
`define ADDR_FRAC_BYTE_MID 7'h01
`define ADDR_FRAC_BYTE_HIGH 7'h02
`define ADDR_FRAC_TOP_BIT 7'h03
`define ADDR_REF_DIVIDER_ENABLE 7'h05
`define ADDR_INT_BYTE_LOW 7'h06
`define ADDR_INT_HIGH_AND_TEST_OUT 7'h07
`define ADDR_PUMP_CURRENT 7'h09
`define ADDR_REF_PATH_CONTROL 7'h0a
`define ADDR_PLL_POWER 7'h0c
`define ADDR_TX_OFF_GATING 7'h0e
// field positions
`define POS_REF_DIV_EN 4
`define POS_TEST_SEL_LSB 4
`define POS_PUMP_LSB 4
`define POS_REF_HALF 6
`define POS_REF_DOUBLER 5
`define POS_PLL_DOWN 2
`define POS_GATE_ATT 5
`define POS_GATE_LO_BUF 4
`define POS_GATE_QUAD 3
`define POS_GATE_LO_DBL 1
`define POS_GATE_RF_MON 0
// reset values
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_REF_CODE 5'h00
`define RST_BIT 1'b0
// test output select codes
`define TEST_TRISTATE 4'h0
`define TEST_HIGH 4'h1
`define TEST_LOW 4'h2
`define TEST_REF_HALF 4'hd
`define TEST_FB_HALF 4'he
// reference divider code zero means divide by 32
`define REF_CODE_ZERO 5'h00
`define REF_RATIO_MAX 6'h20
`endif

// *** hw/serial_control_port.v ***
// serial control port: 16-bit frames, mode 0, msb first
// assumes spi pins arrive unsynchronised to clk; sclk at most clk/8
`timescale 1ns/10ps
`include "synth_ctrl_defines.vh"
module serial_control_port (
  input wire clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  input wire [7:0] rd_data,
  output reg [6:0] addr,
  output reg wr_en,
  output reg [7:0] wr_data
);
  reg sclk_s1, sclk_s2, sclk_d;
  reg cs_s1, cs_s2;
  reg mosi_s1, mosi_s2;
  reg [4:0] bit_cnt;
  reg [14:0] shift;
  reg [7:0] out_sr;
  reg is_read;
  reg load_rd;
  wire active = ~cs_s2;
  wire rise = active & sclk_s2 & ~sclk_d;
  wire fall = active & ~sclk_s2 & sclk_d;

  // two flops before any logic reads a pin
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 5'h00;
      shift <= 15'h0000;
      out_sr <= 8'h00;
      is_read <= 1'b0;
      load_rd <= 1'b0;
      addr <= 7'h00;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      load_rd <= 1'b0;
      if (!active) begin
        // an aborted frame writes nothing
        bit_cnt <= 5'h00;
        is_read <= 1'b0;
      end else if (rise) begin
        shift <= {shift[13:0], mosi_s2};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == `HEAD_LAST) begin
          is_read <= shift[6];
          addr <= {shift[5:0], mosi_s2};
          load_rd <= shift[6];
        end
        if (bit_cnt == `FRAME_LAST && !is_read) begin
          wr_en <= 1'b1;
          wr_data <= {shift[6:0], mosi_s2};
        end
      end else if (fall && is_read && bit_cnt > `HEAD_LAST + 5'h01) begin
        out_sr <= {out_sr[6:0], 1'b0};
      end
      if (load_rd) begin
        out_sr <= rd_data;
      end
    end
  end

  assign spi_miso = out_sr[7];
  assign spi_miso_oe = active & is_read & (bit_cnt > `HEAD_LAST);
endmodule // serial_control_port

// *** hw/synth_control_register_bank.v ***
// synthesizer control register bank with double-buffered loop settings
// assumes spi, tx_off_pin and reference/feedback clocks arrive unsynchronised
//
// Function
// - fractional bits 0..7 live in byte register 0x00.
// - fractional bits 8..15 live in byte register 0x01.
// - fractional bits 16..23 live in byte register 0x02.
// - fractional bit 24 is bit 0 of 0x03; other bits reserved.
// - loop fields go to shadows, all committed together on write to 0x00.
// - integer word: low byte at 0x06, high nibble at 0x07 bits 3..0.
// - 0x07 bits 7..4 select test pin: tristate, high, low, ref/2, fb/2.
// - 0x09 bits 7..4 pick one of sixteen pump currents, default lowest.
// - 0x05 bit 4 enables reference divider, default off.
// - 0x0a bits 4..0 give reference ratio; zero means 32, default.
// - 0x0a bit 5 enables reference doubler, default off.
// - 0x0a bit 6 inserts divide-by-two stage, default bypassed.
// - 0x0c bit 2 powers down the pll, default powered.
// - 0x0e bit 5 disables attenuator while tx off pin high.
// - 0x0e bit 4 disables lo buffer while tx off pin high.
// - 0x0e bit 3 disables quadrature divider while tx off pin high.
// - 0x0e bit 1 disables lo doubler while tx off pin high.
// - 0x0e bit 0 disables rf monitor while tx off pin high.
// - every register is readable and writable over the control port.
`timescale 1ns/10ps
`include "synth_ctrl_defines.vh"
module synth_control_register_bank (
  input wire clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  input wire tx_off_pin,
  input wire ref_clk_pin,
  input wire feedback_clock_div,
  output reg [24:0] frac_word,
  output reg [11:0] int_word,
  output reg new_word_load,
  output reg ref_div_en,
  output reg [5:0] ref_div_ratio,
  output reg ref_doubler_en,
  output reg ref_half_en,
  output reg [3:0] pump_code,
  output reg pll_powerdown,
  output reg attenuator_en,
  output reg lo_buffer_en,
  output reg quadrature_divider_en,
  output reg lo_doubler_en,
  output reg rf_monitor_en,
  output reg test_out,
  output reg test_out_oe
);
  wire [6:0] addr;
  wire wr_en;
  wire [7:0] wr_data;
  reg [7:0] rd_data;

  // shadow copies, which are what the host reads back
  reg [7:0] frac_byte_low;
  reg [7:0] frac_byte_mid;
  reg [7:0] frac_byte_high;
  reg frac_msb;
  reg ref_div_en_sh;
  reg [7:0] int_byte_low;
  reg [3:0] int_high_sh;
  reg [3:0] pump_sh;
  reg ref_half_sh;
  reg ref_doubler_sh;
  reg [4:0] ref_code_sh;
  // immediate fields, acting one edge after their write
  // reserved bits have no storage, so they can steer nothing
  reg [3:0] test_sel;
  reg pll_down;
  reg gate_attenuator_on_tx_off;
  reg gate_lo_buffer_on_tx_off;
  reg gate_quad_divider_on_tx_off;
  reg gate_lo_doubler_on_tx_off;
  reg gate_rf_monitor_on_tx_off;

  // pin synchronisers
  reg tx_s1, tx_s2;
  reg ref_s1, ref_s2, ref_d;
  reg fb_s1, fb_s2, fb_d;
  reg ref_half_clk;
  reg fb_half_clk;

  // the port decodes frames; storage and decode of the bank stay here
  serial_control_port serial_control_port_inst (
    .clk(clk),
    .resetn(resetn),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .rd_data(rd_data),
    .addr(addr),
    .wr_en(wr_en),
    .wr_data(wr_data)
  );

  function hit;
    input [6:0] a;
    input [6:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  function [5:0] ref_ratio;
    input [4:0] code;
    begin
      if (code == `REF_CODE_ZERO) begin
        ref_ratio = `REF_RATIO_MAX;
      end else begin
        ref_ratio = {1'b0, code};
      end
    end
  endfunction

  // read decode; unmapped addresses and reserved bits read zero
  // reads return shadows, so a readback shows what the next commit loads, except 0x00, whose commit takes the written byte
  always @* begin
    rd_data = 8'h00;
    if (hit(addr, `ADDR_FRAC_BYTE_LOW)) begin
      rd_data = frac_byte_low;
    end else if (hit(addr, `ADDR_FRAC_BYTE_MID)) begin
      rd_data = frac_byte_mid;
    end else if (hit(addr, `ADDR_FRAC_BYTE_HIGH)) begin
      rd_data = frac_byte_high;
    end else if (hit(addr, `ADDR_FRAC_TOP_BIT)) begin
      rd_data = {7'h00, frac_msb};
    end else if (hit(addr, `ADDR_REF_DIVIDER_ENABLE)) begin
      rd_data[`POS_REF_DIV_EN] = ref_div_en_sh;
    end else if (hit(addr, `ADDR_INT_BYTE_LOW)) begin
      rd_data = int_byte_low;
    end else if (hit(addr, `ADDR_INT_HIGH_AND_TEST_OUT)) begin
      rd_data = {test_sel, int_high_sh};
    end else if (hit(addr, `ADDR_PUMP_CURRENT)) begin
      rd_data = {pump_sh, 4'h0};
    end else if (hit(addr, `ADDR_REF_PATH_CONTROL)) begin
      rd_data = {1'b0, ref_half_sh, ref_doubler_sh, ref_code_sh};
    end else if (hit(addr, `ADDR_PLL_POWER)) begin
      rd_data[`POS_PLL_DOWN] = pll_down;
    end else if (hit(addr, `ADDR_TX_OFF_GATING)) begin
      rd_data[`POS_GATE_ATT] = gate_attenuator_on_tx_off;
      rd_data[`POS_GATE_LO_BUF] = gate_lo_buffer_on_tx_off;
      rd_data[`POS_GATE_QUAD] = gate_quad_divider_on_tx_off;
      rd_data[`POS_GATE_LO_DBL] = gate_lo_doubler_on_tx_off;
      rd_data[`POS_GATE_RF_MON] = gate_rf_monitor_on_tx_off;
    end
  end

  // register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frac_byte_low <= `RST_BYTE;
      frac_byte_mid <= `RST_BYTE;
      frac_byte_high <= `RST_BYTE;
      frac_msb <= `RST_BIT;
      ref_div_en_sh <= `RST_BIT;
      int_byte_low <= `RST_BYTE;
      int_high_sh <= `RST_NIBBLE;
      pump_sh <= `RST_NIBBLE;
      ref_half_sh <= `RST_BIT;
      ref_doubler_sh <= `RST_BIT;
      ref_code_sh <= `RST_REF_CODE;
      test_sel <= `RST_NIBBLE;
      pll_down <= `RST_BIT;
      gate_attenuator_on_tx_off <= `RST_BIT;
      gate_lo_buffer_on_tx_off <= `RST_BIT;
      gate_quad_divider_on_tx_off <= `RST_BIT;
      gate_lo_doubler_on_tx_off <= `RST_BIT;
      gate_rf_monitor_on_tx_off <= `RST_BIT;
    end else if (wr_en) begin
      if (hit(addr, `ADDR_FRAC_BYTE_LOW)) begin
        frac_byte_low <= wr_data;
      end else if (hit(addr, `ADDR_FRAC_BYTE_MID)) begin
        frac_byte_mid <= wr_data;
      end else if (hit(addr, `ADDR_FRAC_BYTE_HIGH)) begin
        frac_byte_high <= wr_data;
      end else if (hit(addr, `ADDR_FRAC_TOP_BIT)) begin
        frac_msb <= wr_data[0];
      end else if (hit(addr, `ADDR_REF_DIVIDER_ENABLE)) begin
        ref_div_en_sh <= wr_data[`POS_REF_DIV_EN];
      end else if (hit(addr, `ADDR_INT_BYTE_LOW)) begin
        int_byte_low <= wr_data;
      end else if (hit(addr, `ADDR_INT_HIGH_AND_TEST_OUT)) begin
        int_high_sh <= wr_data[3:0];
        test_sel <= wr_data[7:4];
      end else if (hit(addr, `ADDR_PUMP_CURRENT)) begin
        pump_sh <= wr_data[7:4];
      end else if (hit(addr, `ADDR_REF_PATH_CONTROL)) begin
        ref_half_sh <= wr_data[`POS_REF_HALF];
        ref_doubler_sh <= wr_data[`POS_REF_DOUBLER];
        ref_code_sh <= wr_data[4:0];
      end else if (hit(addr, `ADDR_PLL_POWER)) begin
        pll_down <= wr_data[`POS_PLL_DOWN];
      end else if (hit(addr, `ADDR_TX_OFF_GATING)) begin
        gate_attenuator_on_tx_off <= wr_data[`POS_GATE_ATT];
        gate_lo_buffer_on_tx_off <= wr_data[`POS_GATE_LO_BUF];
        gate_quad_divider_on_tx_off <= wr_data[`POS_GATE_QUAD];
        gate_lo_doubler_on_tx_off <= wr_data[`POS_GATE_LO_DBL];
        gate_rf_monitor_on_tx_off <= wr_data[`POS_GATE_RF_MON];
      end
    end
  end

  // commit of the double-buffered set; the new low byte joins in the same edge
  // the loop never sees half a setting, since every field moves on one edge
  wire commit = wr_en & hit(addr, `ADDR_FRAC_BYTE_LOW);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frac_word <= 25'h0000000;
      int_word <= 12'h000;
      new_word_load <= 1'b0;
      ref_div_en <= `RST_BIT;
      ref_div_ratio <= `REF_RATIO_MAX;
      ref_doubler_en <= `RST_BIT;
      ref_half_en <= `RST_BIT;
      pump_code <= `RST_NIBBLE;
    end else begin
      new_word_load <= commit;
      if (commit) begin
        frac_word <= {frac_msb, frac_byte_high, frac_byte_mid, wr_data};
        int_word <= {int_high_sh, int_byte_low};
        ref_div_en <= ref_div_en_sh;
        ref_div_ratio <= ref_ratio(ref_code_sh);
        ref_doubler_en <= ref_doubler_sh;
        ref_half_en <= ref_half_sh;
        pump_code <= pump_sh;
      end
    end
  end

  // transmit-disable pin; two flops before the enables read it
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_s1 <= 1'b0;
      tx_s2 <= 1'b0;
    end else begin
      tx_s1 <= tx_off_pin;
      tx_s2 <= tx_s1;
    end
  end

  // clock pins, sampled for the test output only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_d <= 1'b0;
      fb_s1 <= 1'b0;
      fb_s2 <= 1'b0;
      fb_d <= 1'b0;
      ref_half_clk <= 1'b0;
      fb_half_clk <= 1'b0;
    end else begin
      ref_s1 <= ref_clk_pin;
      ref_s2 <= ref_s1;
      ref_d <= ref_s2;
      fb_s1 <= feedback_clock_div;
      fb_s2 <= fb_s1;
      fb_d <= fb_s2;
      // halving by toggling on each sampled rising edge; clocks above clk/4 alias
      if (ref_s2 && !ref_d) begin
        ref_half_clk <= ~ref_half_clk;
      end
      if (fb_s2 && !fb_d) begin
        fb_half_clk <= ~fb_half_clk;
      end
    end
  end

  // block enables follow the gating bits at once; no shadow on these
  wire [4:0] gate_bits = {gate_attenuator_on_tx_off, gate_lo_buffer_on_tx_off,
    gate_quad_divider_on_tx_off, gate_lo_doubler_on_tx_off, gate_rf_monitor_on_tx_off};
  wire [4:0] next_en;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gate_loop
      // a clear gating bit keeps its block on whatever the pin does
      assign next_en[gi] = ~(gate_bits[gi] & tx_s2);
    end
  endgenerate
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_powerdown <= 1'b0;
      attenuator_en <= 1'b1;
      lo_buffer_en <= 1'b1;
      quadrature_divider_en <= 1'b1;
      lo_doubler_en <= 1'b1;
      rf_monitor_en <= 1'b1;
    end else begin
      pll_powerdown <= pll_down;
      attenuator_en <= next_en[4];
      lo_buffer_en <= next_en[3];
      quadrature_divider_en <= next_en[2];
      lo_doubler_en <= next_en[1];
      rf_monitor_en <= next_en[0];
    end
  end

  // test output mux; codes not listed float the pin
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      test_out <= 1'b0;
      test_out_oe <= 1'b0;
    end else begin
      case (test_sel)
        `TEST_TRISTATE: begin
          test_out <= 1'b0;
          test_out_oe <= 1'b0;
        end
        `TEST_HIGH: begin
          test_out <= 1'b1;
          test_out_oe <= 1'b1;
        end
        `TEST_LOW: begin
          test_out <= 1'b0;
          test_out_oe <= 1'b1;
        end
        `TEST_REF_HALF: begin
          test_out <= ref_half_clk;
          test_out_oe <= 1'b1;
        end
        `TEST_FB_HALF: begin
          test_out <= fb_half_clk;
          test_out_oe <= 1'b1;
        end
        default: begin
          test_out <= 1'b0;
          test_out_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule // synth_control_register_bank

// *** testbench/spi_host_model.sv ***
// host side of the serial control port: mode 0, msb first, 16-bit frames
// assumes clk is the bank clock; each sclk phase lasts 5 clk, above the 4 clk minimum
`timescale 1ns/10ps
module spi_host_model (
  input wire clk,
  input wire spi_miso,
  input wire spi_miso_oe,
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_mosi,
  output reg [7:0] rd_byte,
  output reg rd_done
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rd_byte = 8'h00;
    rd_done = 1'b0;
  end
  task half;
    begin
      repeat (5) @(posedge clk);
      #1;
    end
  endtask
  // fewer than 16 bits aborts the frame; sclk stands low outside frames
  task frame(input rd, input [6:0] a, input [7:0] d, input integer nbits);
    reg [15:0] sr;
    integer i;
    begin
      sr = {rd, a, d};
      @(posedge clk);
      #1;
      spi_cs_n = 1'b0;
      for (i = 0; i < nbits; i = i + 1) begin
        spi_mosi = sr[15];
        half;
        // a released miso reads unknown, so a float never matches
        sr = {sr[14:0], spi_miso_oe ? spi_miso : 1'bx};
        spi_sclk = 1'b1;
        half;
        spi_sclk = 1'b0;
      end
      half;
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      rd_byte = sr[7:0];
      rd_done = rd && nbits == 16;
      @(posedge clk);
      #1;
      rd_done = 1'b0;
      half;
    end
  endtask
endmodule // spi_host_model

// *** testbench/synth_bank_assertions.sv ***
// port checker for the synthesizer control register bank
// assumes it is bound onto every instance of the bank
`timescale 1ns/10ps
module synth_bank_checker (
  input wire clk,
  input wire resetn,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire tx_off_pin,
  input wire [24:0] frac_word,
  input wire [11:0] int_word,
  input wire new_word_load,
  input wire ref_div_en,
  input wire [5:0] ref_div_ratio,
  input wire ref_doubler_en,
  input wire ref_half_en,
  input wire [3:0] pump_code,
  input wire pll_powerdown,
  input wire attenuator_en,
  input wire lo_buffer_en,
  input wire quadrature_divider_en,
  input wire lo_doubler_en,
  input wire rf_monitor_en,
  input wire test_out_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [49:0] loop_set = {frac_word, int_word, ref_div_en, ref_div_ratio,
    ref_doubler_en, ref_half_en, pump_code};
  // four samples cover the two sync stages plus the output register
  sequence pin_low4; !tx_off_pin [*4]; endsequence
  sequence cs_idle; spi_cs_n [*5]; endsequence
  property held_on(en); pin_low4 |-> en; endproperty
  gate_att_a: assert property (held_on(attenuator_en)) else $error("attenuator off");
  gate_lo_buffer_a: assert property (held_on(lo_buffer_en)) else $error("lo buffer off");
  gate_quad_a: assert property (held_on(quadrature_divider_en)) else $error("quad off");
  gate_lodbl_a: assert property (held_on(lo_doubler_en)) else $error("lo doubler off");
  gate_rf_monitor_a: assert property (held_on(rf_monitor_en)) else $error("monitor off");
  commit_only_a: assert property ($changed(loop_set) |-> (##[0:2] new_word_load)
    or $past(new_word_load)) else $error("loop setting moved without commit");
  load_pulse_a: assert property (new_word_load |=> !new_word_load) else $error("long load");
  ratio_range_a: assert property (ref_div_ratio != 6'h00 && ref_div_ratio <= 6'h20)
    else $error("reference ratio out of range");
  miso_quiet_a: assert property (cs_idle |-> !spi_miso_oe) else $error("miso driven idle");
  reset_vals_a: assert property (disable iff (1'b0) !resetn ##1 resetn |->
    ref_div_ratio == 6'h20 && pump_code == 4'h0 && !pll_powerdown && !test_out_oe
    && !ref_doubler_en && !ref_half_en && !ref_div_en) else $error("bad reset");
endmodule // synth_bank_checker
bind synth_control_register_bank synth_bank_checker synth_bank_checker_inst (.clk, .resetn,
  .spi_cs_n, .spi_miso_oe, .tx_off_pin, .frac_word, .int_word, .new_word_load, .ref_div_en,
  .ref_div_ratio, .ref_doubler_en, .ref_half_en, .pump_code, .pll_powerdown, .attenuator_en,
  .lo_buffer_en, .quadrature_divider_en, .lo_doubler_en, .rf_monitor_en, .test_out_oe);

// *** testbench/test_synth_control_register_bank.sv ***
// self-checking bench for the synthesizer control register bank
// assumes the host model is the only master of the serial port
`timescale 1ns/10ps
module test_synth_control_register_bank;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg tx_off_pin = 1'b0;
  reg ref_clk_pin = 1'b0;
  reg feedback_clock_div = 1'b0;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, rd_done;
  wire [7:0] rd_byte;
  wire [24:0] frac_word;
  wire [11:0] int_word;
  wire [5:0] ref_div_ratio;
  wire [3:0] pump_code;
  wire new_word_load, ref_div_en, ref_doubler_en, ref_half_en, pll_powerdown;
  wire attenuator_en, lo_buffer_en, quadrature_divider_en, lo_doubler_en, rf_monitor_en;
  wire test_out, test_out_oe;
  wire [4:0] ens = {attenuator_en, lo_buffer_en, quadrature_divider_en, lo_doubler_en,
    rf_monitor_en};
  // readable bits per address, 0x00 in the low byte; unmapped places read zero
  localparam [127:0] masks = 128'h003b0004007ff000ffff100001ffffff;
  integer failures = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer loads = 0;
  reg fl;
  integer i, k, n;
  reg [7:0] expect_q[$];
  reg [7:0] val [0:15];
  reg [7:0] e, g;
  reg t_prev;
  always #2.5 clk = ~clk;
  // both test clocks stay below clk/4
  always #11 ref_clk_pin = ~ref_clk_pin;
  always #15 feedback_clock_div = ~feedback_clock_div;
  spi_host_model spi_host_model_inst (.clk, .spi_miso, .spi_miso_oe, .spi_sclk, .spi_cs_n,
    .spi_mosi, .rd_byte, .rd_done);
  synth_control_register_bank synth_control_register_bank_inst (.clk, .resetn, .spi_sclk,
    .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .tx_off_pin, .ref_clk_pin,
    .feedback_clock_div, .frac_word, .int_word, .new_word_load, .ref_div_en, .ref_div_ratio,
    .ref_doubler_en, .ref_half_en, .pump_code, .pll_powerdown, .attenuator_en, .lo_buffer_en,
    .quadrature_divider_en, .lo_doubler_en, .rf_monitor_en, .test_out, .test_out_oe);
  task give_verdict;
    begin
      if (failures == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task check(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    spi_host_model_inst.frame(1'b0, a, d, 16);
  endtask
  task rd(input [6:0] a, input [7:0] exp);
    begin
      expect_q.push_back(exp);
      spi_host_model_inst.frame(1'b1, a, 8'h00, 16);
    end
  endtask
  // watcher: each finished read takes the oldest expectation
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (new_word_load === 1'b1) loads = loads + 1;
    if (rd_done === 1'b1) begin
      e = expect_q.pop_front();
      check(rd_byte, e);
    end
    if (cycles == 40000) begin
      failures = failures + 1;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(12105));
    tick(16);
    resetn = 1'b1;
    tick(3);
    for (i = 0; i < 16; i = i + 1) rd(i[6:0], 8'h00);
    check({ref_div_ratio, pump_code, ens, test_out_oe}, {6'h20, 4'h0, 5'h1f, 1'b0});
    // everything but 0x00 first, so actives must not move yet
    for (i = 15; i > 0; i = i - 1) begin
      val[i] = $urandom;
      wr(i[6:0], val[i]);
    end
    for (i = 1; i < 16; i = i + 1) rd(i[6:0], val[i] & masks[i*8 +: 8]);
    check({frac_word, int_word, pump_code, ref_div_ratio}, {25'h0, 12'h0, 4'h0, 6'h20});
    check(pll_powerdown, val[12][2]);
    check(ens, 5'h1f);
    check(loads, 0);
    val[0] = $urandom;
    wr(7'h00, val[0]);
    tick(2);
    check(loads, 1);
    check(frac_word, {val[3][0], val[2], val[1], val[0]});
    check(int_word, {val[7][3:0], val[6]});
    check({pump_code, ref_div_en}, {val[9][7:4], val[5][4]});
    check({ref_half_en, ref_doubler_en}, val[10][6:5]);
    check(ref_div_ratio, val[10][4:0] == 5'h00 ? 6'h20 : {1'b0, val[10][4:0]});
    // boundary codes: ratio 32 with lowest pump, ratio 31 with highest
    for (k = 0; k < 2; k = k + 1) begin
      wr(7'h0a, k ? 8'h1f : 8'h00);
      wr(7'h09, k ? 8'hf0 : 8'h00);
      wr(7'h00, 8'h00);
      tick(2);
      check({ref_div_ratio, pump_code}, k ? {6'h1f, 4'hf} : {6'h20, 4'h0});
    end
    // one gating bit at a time; bit 2 is reserved and gates nothing
    for (k = 0; k < 6; k = k + 1) begin
      g = 8'h01 << k;
      wr(7'h0e, g);
      tx_off_pin = 1'b1;
      tick(5);
      check(ens, 5'h1f ^ {g[5], g[4], g[3], g[1], g[0]});
      tx_off_pin = 1'b0;
      tick(5);
      check(ens, 5'h1f);
    end
    // test pin codes: tristate, high, low, two halved clocks, an unlisted code floats
    for (k = 0; k < 16; k = k + 1) begin
      if (k < 3 || k > 12) begin
        wr(7'h07, {k[3:0], 4'h0});
        tick(2);
        t_prev = test_out;
        n = 0;
        for (i = 0; i < 24; i = i + 1) begin
          tick(1);
          n = n + (test_out !== t_prev);
          t_prev = test_out;
        end
        fl = (k == 0 || k == 15);
        check({test_out_oe, fl ? 1'b0 : (k < 3 ? test_out : n > 2)}, {!fl, !fl && k != 2});
      end
    end
    // a frame cut short after 9 bits must write nothing
    spi_host_model_inst.frame(1'b0, 7'h06, ~val[6], 9);
    rd(7'h06, val[6]);
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(3);
    rd(7'h0e, 8'h00);
    check({ref_div_ratio, frac_word}, {6'h20, 25'h0});
    tick(20);
    give_verdict;
  end
endmodule // test_synth_control_register_bank
